// ### dsa_pkg.sv
// shared constants and types for the dsp alu block
`default_nettype none
package dsa_pkg;
	localparam int FULL_W = 40;
	localparam int BASE_W = 32;
	localparam int GUARD_W = 8;
	localparam int WORD_W = 16;
	localparam int NREGS = 8;
	localparam int MSB_BASE = 31;
	localparam int MSB_FULL = 39;
	localparam int INT_LSB = 16;
	// register indices
	localparam logic [2:0] IDX_ACC0 = 3'h0;
	localparam logic [2:0] IDX_ACC1 = 3'h1;
	localparam logic [2:0] IDX_M0 = 3'h2;
	localparam logic [2:0] IDX_M1 = 3'h3;
	localparam logic [2:0] IDX_X0 = 3'h4;
	localparam logic [2:0] IDX_X1 = 3'h5;
	localparam logic [2:0] IDX_Y0 = 3'h6;
	localparam logic [2:0] IDX_Y1 = 3'h7;
	// integer step values aligned to the upper word
	localparam logic [39:0] INT_PLUS = 40'h0000010000;
	localparam logic [39:0] INT_MINUS = 40'hffffff0000;
	// saturation limits
	localparam logic [39:0] SAT32_POS = 40'h007fffffff;
	localparam logic [39:0] SAT32_NEG = 40'hff80000000;
	localparam logic [39:0] SAT16_POS = 40'h007fff0000;
	localparam logic [39:0] SAT40_POS = 40'h7fffffffff;
	localparam logic [39:0] SAT40_NEG = 40'h8000000000;
	localparam logic [39:0] ZERO40 = 40'h0000000000;
	localparam logic [15:0] ZERO16 = 16'h0000;
	localparam logic [1:0] RST_SYNC_INIT = 2'h0;
	typedef enum logic [3:0] {
		DSA_ADD = 4'h0,
		DSA_SUB = 4'h1,
		DSA_ADD_CARRY = 4'h2,
		DSA_SUB_BORROW = 4'h3,
		DSA_COMPARE = 4'h4,
		DSA_COPY = 4'h5,
		DSA_ABSOLUTE = 4'h6,
		DSA_NEGATE = 4'h7,
		DSA_CLEAR = 4'h8,
		DSA_INCREMENT = 4'h9,
		DSA_DECREMENT = 4'ha,
		DSA_NOP = 4'hf
	} dsa_op_e;
	typedef enum logic [2:0] {
		CS_CARRY = 3'h0,
		CS_NEGATIVE = 3'h1,
		CS_ZERO = 3'h2,
		CS_OVERFLOW = 3'h3,
		CS_GREATER = 3'h4,
		CS_GREATER_EQ = 3'h5
	} dsa_cond_e;
	typedef struct packed {
		logic dc;
		logic neg;
		logic zero;
		logic ovf;
		logic gt;
		logic [39:0] rd;
	} dsa_state_s;
	typedef struct packed {
		logic [NREGS-1:0][FULL_W-1:0] r;
	} dsa_file_s;
endpackage : dsa_pkg
`default_nettype wire

// ### dsa_regfile.sv
// dsp register file: two guarded accumulators and six guardless registers
`default_nettype none
module dsa_regfile
	import dsa_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [2:0] rd_a_idx,
	input wire logic [2:0] rd_b_idx,
	input wire logic [2:0] rd_c_idx,
	output logic [39:0] rd_a_data,
	output logic [39:0] rd_b_data,
	output logic [39:0] rd_c_data,
	input wire logic wr0_en,
	input wire logic [2:0] wr0_idx,
	input wire logic [39:0] wr0_data,
	input wire logic wr1_en,
	input wire logic [2:0] wr1_idx,
	input wire logic [39:0] wr1_data,
	input wire logic ld_en,
	input wire logic [2:0] ld_idx,
	input wire logic [15:0] ld_word
);
	dsa_file_s file_reg;
	dsa_file_s file_next;

	// guardless registers keep only the low 32 bits, held sign-extended
	function automatic logic [39:0] fit(input logic [2:0] idx, input logic [39:0] d);
		if (idx == IDX_ACC0 || idx == IDX_ACC1) begin
			fit = d;
		end else begin
			fit = {{GUARD_W{d[MSB_BASE]}}, d[BASE_W-1:0]};
		end
	endfunction : fit

	// entries are flops, so read data come straight from registers
	assign rd_a_data = file_reg.r[rd_a_idx];
	assign rd_b_data = file_reg.r[rd_b_idx];
	assign rd_c_data = file_reg.r[rd_c_idx];

	// alu writes first, the parallel load lands last and wins
	always_comb begin
		file_next = file_reg;
		if (wr0_en) begin
			file_next.r[wr0_idx] = fit(wr0_idx, wr0_data);
		end
		if (wr1_en) begin
			file_next.r[wr1_idx] = fit(wr1_idx, wr1_data);
		end
		if (ld_en) begin
			file_next.r[ld_idx] = {{GUARD_W{ld_word[WORD_W-1]}}, ld_word, ZERO16};
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			file_reg <= '0;
		end else begin
			file_reg <= file_next;
		end
	end
endmodule : dsa_regfile
`default_nettype wire

// ### dsa_alu.sv
// dsp alu: fixed-point and integer arithmetic with condition flags
`default_nettype none
// Notes on behaviour
// - fixed-point is 40 bits, guardless sources sign-extended
// - guardless destination takes low 32 bits
// - add, sub, carry forms, compare, copy, abs, negate, clear
// - source, destination and secondary selection sets
// - same-line loads never feed sources; written afterwards
// - conditional operations leave all flags unchanged
// - mode 000 gives carry/borrow from bit 31
// - abs/negate of negative adds one, carry counts
// - mode 001 gives bit 39 of result
// - mode 010 flags an all-zero result
// - mode 011 flags overflow of 32-bit range
// - mode 100 is signed greater-than with correction
// - mode 101 is signed greater-or-equal with correction
// - ge equals inverse of negative xor over-range
// - gt equals ge, cleared on zero result
// - n, z, v, gt flags ignore mode select
// - carry forms always write carry or borrow
// - saturation bit enables overflow protection
// - guard bits take part when present
// - integer ops are increment or decrement only
// - integer ops use upper 24 bits
// - integer ignores source low word, clears destination's, except a guarded clamp to SAT40_POS
// - integer flags derived without low words
// - loaded words land in upper word
module dsa_alu
	import dsa_pkg::*;
(
	input wire logic clk,
	input wire logic nrst,
	input wire logic op_valid,
	input wire logic [3:0] op_code,
	input wire logic cond_exec,
	input wire logic cond_true,
	input wire logic [1:0] first_source,
	input wire logic [1:0] second_source,
	input wire logic use_second,
	input wire logic [2:0] destination_reg,
	input wire logic sec_dst_en,
	input wire logic [1:0] secondary_destination,
	input wire logic [2:0] condition_select,
	input wire logic saturation_bit,
	input wire logic load_valid,
	input wire logic [2:0] load_sel,
	input wire logic [15:0] load_word,
	input wire logic [2:0] view_sel,
	output logic [39:0] view_data,
	output logic selectable_condition_flag,
	output logic negative_flag,
	output logic zero_flag,
	output logic overflow_flag,
	output logic greater_flag
);
	////////////////////////////////////////////////////////////////////////////////
	logic [1:0] rst_sync_reg;
	logic rst_n;
	dsa_state_s st_reg;
	dsa_state_s st_next;
	dsa_op_e op;
	logic [2:0] x_idx, y_idx, du_idx;
	logic [39:0] xv, yv, cv, pick, opa, opb, bb, res, wdata;
	logic [40:0] sum;
	logic [32:0] lo;
	logic cin, sub, carry32, neg, zero, ovr, ovf, ge, gt;
	logic is_int, has_dst, exec, upd, wr0_en, wr1_en, guarded_dst;

	// reset release through two flops
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			rst_sync_reg <= RST_SYNC_INIT;
		end else begin
			rst_sync_reg <= {rst_sync_reg[0], 1'b1};
		end
	end
	assign rst_n = rst_sync_reg[1];

	////////////////////////////////////////////////////////////////////////////////
	// operand selection maps
	function automatic logic [2:0] map_x(input logic [1:0] s);
		case (s)
			2'h0: map_x = IDX_ACC0;
			2'h1: map_x = IDX_ACC1;
			2'h2: map_x = IDX_X0;
			default: map_x = IDX_X1;
		endcase
	endfunction : map_x

	function automatic logic [2:0] map_y(input logic [1:0] s);
		case (s)
			2'h0: map_y = IDX_M0;
			2'h1: map_y = IDX_M1;
			2'h2: map_y = IDX_Y0;
			default: map_y = IDX_Y1;
		endcase
	endfunction : map_y

	function automatic logic [2:0] map_du(input logic [1:0] s);
		case (s)
			2'h0: map_du = IDX_ACC0;
			2'h1: map_du = IDX_ACC1;
			2'h2: map_du = IDX_X0;
			default: map_du = IDX_Y0;
		endcase
	endfunction : map_du

	assign op = dsa_op_e'(op_code);
	assign x_idx = map_x(first_source);
	assign y_idx = map_y(second_source);
	assign du_idx = map_du(secondary_destination);

	// sources read the pre-load contents of the file
	dsa_regfile u_file (
		.clk(clk),
		.rst_n(rst_n),
		.rd_a_idx(x_idx),
		.rd_b_idx(y_idx),
		.rd_c_idx(view_sel),
		.rd_a_data(xv),
		.rd_b_data(yv),
		.rd_c_data(cv),
		.wr0_en(wr0_en),
		.wr0_idx(destination_reg),
		.wr0_data(wdata),
		.wr1_en(wr1_en),
		.wr1_idx(du_idx),
		.wr1_data(wdata),
		.ld_en(load_valid),
		.ld_idx(load_sel),
		.ld_word(load_word)
	);

	////////////////////////////////////////////////////////////////////////////////
	// operand steering per operation
	always_comb begin
		pick = use_second ? yv : xv;
		opa = ZERO40;
		opb = ZERO40;
		cin = 1'b0;
		sub = 1'b0;
		is_int = 1'b0;
		has_dst = 1'b1;
		case (op)
			DSA_ADD: begin
				opa = xv;
				opb = yv;
			end
			DSA_SUB: begin
				opa = xv;
				opb = yv;
				sub = 1'b1;
			end
			DSA_ADD_CARRY: begin
				opa = xv;
				opb = yv;
				cin = st_reg.dc;
			end
			DSA_SUB_BORROW: begin
				opa = xv;
				opb = yv;
				sub = 1'b1;
				cin = st_reg.dc;
			end
			DSA_COMPARE: begin
				opa = xv;
				opb = yv;
				sub = 1'b1;
				has_dst = 1'b0;
			end
			DSA_COPY: opa = pick;
			DSA_ABSOLUTE: begin
				opa = pick[MSB_FULL] ? ~pick : pick;
				cin = pick[MSB_FULL];
			end
			DSA_NEGATE: begin
				opa = ~pick;
				cin = 1'b1;
			end
			DSA_CLEAR: opa = ZERO40;
			DSA_INCREMENT: begin
				opa = {pick[MSB_FULL:INT_LSB], ZERO16};
				opb = INT_PLUS;
				is_int = 1'b1;
			end
			DSA_DECREMENT: begin
				opa = {pick[MSB_FULL:INT_LSB], ZERO16};
				opb = INT_MINUS;
				is_int = 1'b1;
			end
			default: has_dst = 1'b0;
		endcase
	end

	////////////////////////////////////////////////////////////////////////////////
	// 41-bit adder; subtract is a + ~b + ~borrow
	assign bb = sub ? ~opb : opb;
	assign sum = {opa[MSB_FULL], opa} + {bb[MSB_FULL], bb} + {40'h0000000000, sub ^ cin};
	assign lo = {1'b0, opa[BASE_W-1:0]} + {1'b0, bb[BASE_W-1:0]} + {32'h00000000, sub ^ cin};
	assign carry32 = sub ? ~lo[BASE_W] : lo[BASE_W];
	assign res = sum[FULL_W-1:0];
	// integer results have a zero low word, so these need no low word
	assign neg = res[MSB_FULL];
	assign zero = (res == ZERO40);
	assign ovr = sum[FULL_W] ^ sum[MSB_FULL];
	assign ovf = !((&sum[FULL_W:MSB_BASE]) || !(|sum[FULL_W:MSB_BASE]));
	assign ge = !(neg ^ ovr);
	assign gt = ge && !zero;

	// protection clamps to destination_reg's own range; the secondary write gets the same value
	assign guarded_dst = (destination_reg == IDX_ACC0) || (destination_reg == IDX_ACC1);
	always_comb begin
		wdata = res;
		if (saturation_bit) begin
			if (guarded_dst && ovr) begin
				wdata = sum[FULL_W] ? SAT40_NEG : SAT40_POS;
			end else if (!guarded_dst && ovf) begin
				wdata = sum[FULL_W] ? SAT32_NEG : (is_int ? SAT16_POS : SAT32_POS);
			end
		end
	end

	assign exec = op_valid && (op != DSA_NOP) && (!cond_exec || cond_true);
	assign upd = exec && !cond_exec;
	assign wr0_en = exec && has_dst;
	assign wr1_en = wr0_en && sec_dst_en && ((op == DSA_ADD) || (op == DSA_SUB));

	////////////////////////////////////////////////////////////////////////////////
	// flag and view register update
	always_comb begin
		st_next = st_reg;
		st_next.rd = cv;
		if (upd) begin
			st_next.neg = neg;
			st_next.zero = zero;
			st_next.ovf = ovf;
			st_next.gt = gt;
			if ((op == DSA_ADD_CARRY) || (op == DSA_SUB_BORROW)) begin
				st_next.dc = carry32;
			end else begin
				case (dsa_cond_e'(condition_select))
					CS_CARRY: st_next.dc = carry32;
					CS_NEGATIVE: st_next.dc = neg;
					CS_ZERO: st_next.dc = zero;
					CS_OVERFLOW: st_next.dc = ovf;
					CS_GREATER: st_next.dc = gt;
					CS_GREATER_EQ: st_next.dc = ge;
					default: st_next.dc = st_reg.dc;
				endcase
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign view_data = st_reg.rd;
	assign selectable_condition_flag = st_reg.dc;
	assign negative_flag = st_reg.neg;
	assign zero_flag = st_reg.zero;
	assign overflow_flag = st_reg.ovf;
	assign greater_flag = st_reg.gt;

	////////////////////////////////////////////////////////////////////////////////
	// checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	a_cond_flags_hold: assert property (op_valid && cond_exec |=>
		$stable({selectable_condition_flag, negative_flag, zero_flag, overflow_flag,
		greater_flag}))
		else $error("flags changed after conditional operation");
	a_cond_false_nowrite: assert property (op_valid && cond_exec && !cond_true |->
		!wr0_en && !wr1_en)
		else $error("write on false condition");
	a_zero_flag_value: assert property (upd && (res == ZERO40) |=> zero_flag)
		else $error("zero flag missed a zero result");
	a_greater_flag_rel: assert property (upd |=>
		greater_flag == (!(negative_flag ^ $past(ovr)) && !zero_flag))
		else $error("greater flag inconsistent");
	a_dc_ge_mode: assert property (upd && condition_select == CS_GREATER_EQ &&
		op != DSA_ADD_CARRY && op != DSA_SUB_BORROW |=>
		selectable_condition_flag == !(negative_flag ^ $past(ovr)))
		else $error("ge mode flag wrong");
	a_dc_neg_mode: assert property (upd && condition_select == CS_NEGATIVE &&
		op != DSA_ADD_CARRY && op != DSA_SUB_BORROW |=>
		selectable_condition_flag == negative_flag)
		else $error("negative mode flag differs from n");
	a_carry_forms_dc: assert property (upd && (op == DSA_ADD_CARRY ||
		op == DSA_SUB_BORROW) |=> selectable_condition_flag == $past(carry32))
		else $error("carry form flag not carry");
	a_int_low_clear: assert property (wr0_en && is_int |-> wdata[15:0] == ZERO16)
		else $error("integer result low word not zero");
	a_src_sign_ext: assert property (x_idx != IDX_ACC0 && x_idx != IDX_ACC1 |->
		xv[MSB_FULL:BASE_W] == {GUARD_W{xv[MSB_BASE]}})
		else $error("guardless source not sign extended");

	c_carry_add: cover property (upd && op == DSA_ADD_CARRY);
	c_cond_exec: cover property (op_valid && cond_exec && cond_true);
	c_saturate: cover property (wr0_en && saturation_bit && ovf);
	c_int_op: cover property (upd && is_int);
endmodule : dsa_alu
`default_nettype wire

// ### dsa_core_model.sv
// core-side issuer model presenting alu operations and word loads
`default_nettype none
module dsa_core_model
	import dsa_pkg::*;
(
	input wire logic clk,
	output logic op_valid,
	output logic [3:0] op_code,
	output logic cond_exec,
	output logic cond_true,
	output logic [1:0] first_source,
	output logic [1:0] second_source,
	output logic use_second,
	output logic [2:0] destination_reg,
	output logic sec_dst_en,
	output logic [1:0] secondary_destination,
	output logic [2:0] condition_select,
	output logic saturation_bit,
	output logic load_valid,
	output logic [2:0] load_sel,
	output logic [15:0] load_word
);
	timeunit 1ns;
	timeprecision 1ns;
	logic ld_arm;
	////////////////////////////////////////
	// quiet issue lines at time zero
	initial begin
		{op_valid, op_code, cond_exec, cond_true, first_source, second_source} = '0;
		{use_second, destination_reg, sec_dst_en, secondary_destination} = '0;
		{condition_select, saturation_bit, load_valid, load_sel, load_word, ld_arm} = '0;
	end
	// one operation for one cycle, with an optional same-line load
	task automatic issue(input dsa_op_e c, input logic [1:0] a, input logic [1:0] b,
		input logic [2:0] d);
		@(negedge clk);
		op_valid = 1'b1;
		op_code = c;
		first_source = a;
		second_source = b;
		destination_reg = d;
		load_valid = ld_arm;
		@(negedge clk);
		op_valid = 1'b0;
		load_valid = 1'b0;
		ld_arm = 1'b0;
	endtask : issue
	// word load on its own
	task automatic load(input logic [2:0] r, input logic [15:0] w);
		@(negedge clk);
		load_valid = 1'b1;
		load_sel = r;
		load_word = w;
		@(negedge clk);
		load_valid = 1'b0;
	endtask : load
endmodule : dsa_core_model
`default_nettype wire

// ### testbench.sv
// self-checking bench for the dsp alu
`default_nettype none
module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	import dsa_pkg::*;
	logic clk = 1'b0;
	logic nrst = 1'b0;
	logic [2:0] view_sel = 3'h0;
	logic [39:0] view_data;
	logic dc, neg, zf, ovf, gtf, op_valid, cond_exec, cond_true, use_second;
	logic sec_dst_en, saturation_bit, load_valid;
	logic [3:0] op_code;
	logic [1:0] first_source, second_source, secondary_destination;
	logic [2:0] destination_reg, condition_select, load_sel;
	logic [15:0] load_word;
	int errors = 0;
	int n_tests = 0;
	int cyc = 0;
	////////////////////////////////////////
	// issuer model and device
	dsa_core_model u_core (.clk(clk), .op_valid(op_valid), .op_code(op_code),
		.cond_exec(cond_exec), .cond_true(cond_true), .first_source(first_source),
		.second_source(second_source), .use_second(use_second),
		.destination_reg(destination_reg), .sec_dst_en(sec_dst_en),
		.secondary_destination(secondary_destination), .condition_select(condition_select),
		.saturation_bit(saturation_bit), .load_valid(load_valid), .load_sel(load_sel),
		.load_word(load_word));
	dsa_alu u_dut (.clk(clk), .nrst(nrst), .op_valid(op_valid), .op_code(op_code),
		.cond_exec(cond_exec), .cond_true(cond_true), .first_source(first_source),
		.second_source(second_source), .use_second(use_second),
		.destination_reg(destination_reg), .sec_dst_en(sec_dst_en),
		.secondary_destination(secondary_destination), .condition_select(condition_select),
		.saturation_bit(saturation_bit), .load_valid(load_valid), .load_sel(load_sel),
		.load_word(load_word), .view_sel(view_sel), .view_data(view_data),
		.selectable_condition_flag(dc), .negative_flag(neg), .zero_flag(zf),
		.overflow_flag(ovf), .greater_flag(gtf));
	// clock and hang guard
	always #5 clk = ~clk;
	always @(posedge clk) begin
		cyc++;
		if (cyc == 2000) begin
			errors++;
			give_verdict();
		end
	end
	////////////////////////////////////////
	// comparison and readback helpers
	task automatic chk(input logic [39:0] got, input logic [39:0] exp);
		n_tests++;
		if (got !== exp) begin
			errors++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic fl(input logic [4:0] e);
		chk({35'h0, dc, neg, zf, ovf, gtf}, {35'h0, e});
	endtask : fl
	task automatic rd(input logic [2:0] r, input logic [39:0] e);
		@(negedge clk);
		view_sel = r;
		@(negedge clk);
		chk(view_data, e);
	endtask : rd
	task automatic give_verdict();
		$display("tests=%0d errors=%0d", n_tests, errors);
		if (errors == 0 && n_tests > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask : give_verdict
	////////////////////////////////////////
	// scenarios
	task automatic t_add();
		rd(IDX_ACC0, 40'h0);
		u_core.load(IDX_X0, 16'h3333);
		u_core.load(IDX_Y0, 16'h5555);
		rd(IDX_X0, 40'h0033330000);
		u_core.sec_dst_en = 1'b1;
		u_core.secondary_destination = 2'h1;
		u_core.issue(DSA_ADD, 2'h2, 2'h2, IDX_ACC0);
		fl(5'h03);
		u_core.sec_dst_en = 1'b0;
		rd(IDX_ACC0, 40'h0088880000);
		rd(IDX_ACC1, 40'h0088880000);
		u_core.ld_arm = 1'b1;
		u_core.load_sel = IDX_X0;
		u_core.load_word = 16'h1111;
		u_core.issue(DSA_ADD, 2'h2, 2'h2, IDX_Y1);
		rd(IDX_Y1, 40'hff88880000);
		rd(IDX_X0, 40'h0011110000);
		$display("test add done");
	endtask : t_add
	task automatic t_modes();
		for (int i = 0; i < 8; i++) begin
			u_core.condition_select = (i < 6) ? 3'(5 - i) : 3'(i);
			u_core.issue(DSA_COMPARE, 2'h2, 2'h2, IDX_ACC0);
			fl({i >= 4, 4'h8});
		end
		rd(IDX_ACC0, 40'h0088880000);
		u_core.load(IDX_Y0, 16'h1111);
		u_core.condition_select = 3'h4;
		u_core.issue(DSA_COMPARE, 2'h2, 2'h2, IDX_ACC0);
		fl(5'h04);
		u_core.condition_select = 3'h5;
		u_core.issue(DSA_COMPARE, 2'h2, 2'h2, IDX_ACC0);
		fl(5'h14);
		$display("test modes done");
	endtask : t_modes
	task automatic t_cond();
		u_core.cond_exec = 1'b1;
		u_core.cond_true = 1'b1;
		u_core.issue(DSA_COPY, 2'h2, 2'h0, IDX_ACC1);
		fl(5'h14);
		rd(IDX_ACC1, 40'h0011110000);
		u_core.cond_true = 1'b0;
		u_core.issue(DSA_CLEAR, 2'h0, 2'h0, IDX_ACC1);
		rd(IDX_ACC1, 40'h0011110000);
		u_core.cond_exec = 1'b0;
		u_core.issue(DSA_NOP, 2'h0, 2'h0, IDX_ACC1);
		fl(5'h14);
		rd(IDX_ACC1, 40'h0011110000);
		$display("test conditional done");
	endtask : t_cond
	task automatic t_negabs();
		u_core.condition_select = 3'h0;
		u_core.issue(DSA_NEGATE, 2'h2, 2'h0, IDX_ACC1);
		fl(5'h08);
		u_core.issue(DSA_NEGATE, 2'h3, 2'h0, IDX_M0);
		fl(5'h14);
		rd(IDX_ACC1, 40'hffeeef0000);
		u_core.issue(DSA_ABSOLUTE, 2'h1, 2'h0, IDX_ACC0);
		fl(5'h01);
		rd(IDX_ACC0, 40'h0011110000);
		$display("test negate done");
	endtask : t_negabs
	task automatic t_carry();
		u_core.condition_select = 3'h2;
		u_core.issue(DSA_SUB_BORROW, 2'h2, 2'h2, IDX_ACC0);
		fl(5'h04);
		u_core.issue(DSA_SUB_BORROW, 2'h3, 2'h2, IDX_ACC1);
		fl(5'h18);
		u_core.issue(DSA_ADD_CARRY, 2'h2, 2'h2, IDX_ACC0);
		fl(5'h01);
		rd(IDX_ACC0, 40'h0022220001);
		u_core.sec_dst_en = 1'b1;
		u_core.secondary_destination = 2'h2;
		u_core.issue(DSA_SUB, 2'h1, 2'h2, IDX_M1);
		u_core.sec_dst_en = 1'b0;
		fl(5'h08);
		rd(IDX_M1, 40'hffddde0000);
		rd(IDX_X0, 40'hffddde0000);
		$display("test carry done");
	endtask : t_carry
	task automatic t_int();
		u_core.condition_select = 3'h3;
		u_core.load(IDX_X1, 16'h7fff);
		u_core.issue(DSA_INCREMENT, 2'h3, 2'h0, IDX_X1);
		fl(5'h13);
		rd(IDX_X1, 40'hff80000000);
		u_core.load(IDX_X1, 16'h7fff);
		u_core.saturation_bit = 1'b1;
		u_core.issue(DSA_INCREMENT, 2'h3, 2'h0, IDX_X1);
		u_core.saturation_bit = 1'b0;
		rd(IDX_X1, SAT16_POS);
		u_core.issue(DSA_INCREMENT, 2'h0, 2'h0, IDX_ACC1);
		fl(5'h01);
		rd(IDX_ACC1, 40'h0022230000);
		u_core.use_second = 1'b1;
		u_core.issue(DSA_DECREMENT, 2'h0, 2'h2, IDX_ACC0);
		u_core.use_second = 1'b0;
		rd(IDX_ACC0, 40'h0011100000);
		u_core.load(IDX_X1, 16'h8000);
		u_core.saturation_bit = 1'b1;
		u_core.issue(DSA_DECREMENT, 2'h3, 2'h0, IDX_X1);
		u_core.saturation_bit = 1'b0;
		fl(5'h1a);
		rd(IDX_X1, SAT32_NEG);
		$display("test integer done");
	endtask : t_int
	////////////////////////////////////////
	// reset then run every scenario
	initial begin
		repeat (3) @(posedge clk);
		@(negedge clk);
		nrst = 1'b1;
		repeat (3) @(posedge clk);
		t_add();
		t_modes();
		t_cond();
		t_negabs();
		t_carry();
		t_int();
		give_verdict();
	end
endmodule : testbench
`default_nettype wire
